// ---- verilog/ltd_core.v ----
// Literal and table operation decoder with APB register access
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
`include "ltd_map.vh"

// What this block does
// - add literal to W, all five flags
// - AND literal into W, Z and N
// - OR literal into W, Z and N
// - XOR literal into W, Z and N
// - literal minus W into W, five flags
// - load literal into W, no flags
// - multiply literal by W, no flags
// - load 4-bit literal into bank select low
// - return with literal in W, two cycles
// - two-word 12-bit pointer load, two cycles
// - table reads take two cycles, no flags
// - table writes take two cycles, no flags
// - low bits pick pointer pre/post update
// - program counter change adds one idle cycle
// - stray second word runs as no-operation
// - port rewrite uses pin levels, not latch
// - timer zero write clears assigned prescaler
// - add literal: single word, one cycle
module ltd_core #(
  parameter PC_W = 20,
  parameter TBLPTR_W = 21
) (
  // Clock, reset and enable
  input wire pclk,
  input wire presetn,
  input wire ce,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_r,
  output reg pready_r,
  output reg pslverr_r,
  // Instruction fetch
  output reg [PC_W-1:0] prog_addr_r,
  input wire [15:0] prog_rdata,
  // Return stack top
  input wire [PC_W-1:0] ret_addr,
  output reg ret_pop_r,
  // Table access to program memory
  output reg [TBLPTR_W-1:0] tbl_addr_r,
  output reg tbl_rd_r,
  output reg tbl_wr_r,
  output reg [7:0] tbl_wdata_r,
  input wire [7:0] tbl_rdata,
  // Port B pins and latch
  input wire [7:0] port_b_pins,
  output reg [7:0] port_b_out_r,
  // Timer zero count and prescaler clear
  output reg [7:0] timer_zero_count_r,
  output reg psc_clr_r
);

  // ----------------------------------------------------------------------
  // Local codes
  // ----------------------------------------------------------------------
  // Sequencer states
  localparam ST_RUN = 1'b0;
  localparam ST_TBL = 1'b1;

  // Operation classes after decode
  localparam [3:0] OP_NOP = 4'h0;
  localparam [3:0] OP_ADD = 4'h1;
  localparam [3:0] OP_AND = 4'h2;
  localparam [3:0] OP_OR = 4'h3;
  localparam [3:0] OP_XOR = 4'h4;
  localparam [3:0] OP_SUB = 4'h5;
  localparam [3:0] OP_MOV = 4'h6;
  localparam [3:0] OP_MUL = 4'h7;
  localparam [3:0] OP_BSR = 4'h8;
  localparam [3:0] OP_RET = 4'h9;
  localparam [3:0] OP_PTR = 4'hA;
  localparam [3:0] OP_TBL = 4'hB;

  // Unit steps sized to their counters
  localparam [PC_W-1:0] PC_ONE = 1;
  localparam [TBLPTR_W-1:0] TP_ONE = 1;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg state_r;
  reg [15:0] ir_r;
  reg ir_valid_r;
  reg [1:0] ctrl_r;
  reg [7:0] working_register_r;
  reg [4:0] flags_r;
  reg [7:0] bsr_r;
  reg [11:0] fsr_r [0:2];
  reg [15:0] prod_r;
  reg [TBLPTR_W-1:0] tblptr_r;
  reg [7:0] tbllat_r;

  // Combinational decode and datapath values
  reg [3:0] op;
  reg [7:0] alu_a;
  reg [7:0] alu_b;
  reg alu_cin;
  reg [8:0] alu_sum;
  reg [4:0] alu_nib;
  reg [7:0] res;
  reg [4:0] flags_nxt;
  reg [31:0] rd_val;
  reg rd_err;
  integer i;

  // Instruction fields, bus qualifiers and side results
  wire [7:0] lit = ir_r[7:0];
  wire [1:0] tbl_mode = ir_r[1:0];
  wire tbl_is_wr = ir_r[2];
  wire running = ctrl_r[`LTD_CTRL_RUN];
  wire apb_acc = psel & penable;
  wire apb_wr = apb_acc & pready_r & pwrite;
  wire [15:0] mul_full = working_register_r * lit;
  wire [TBLPTR_W-1:0] tbl_pre = (tbl_mode == `LTD_TBL_PREINC) ? tblptr_r + TP_ONE : tblptr_r;

  // ----------------------------------------------------------------------
  // Decode of the instruction register
  // ----------------------------------------------------------------------
  always @* begin
    op = OP_NOP;
    case (ir_r[15:8])
      `LTD_OPC_ADD: op = OP_ADD;
      `LTD_OPC_AND: op = OP_AND;
      `LTD_OPC_OR: op = OP_OR;
      `LTD_OPC_XOR: op = OP_XOR;
      `LTD_OPC_SUB: op = OP_SUB;
      `LTD_OPC_MOV: op = OP_MOV;
      `LTD_OPC_MUL: op = OP_MUL;
      `LTD_OPC_RET: op = OP_RET;
      `LTD_OPC_BSR: begin
        if (ir_r[7:4] == 4'h0) op = OP_BSR;
      end
      `LTD_OPC_PTR: begin
        if (ir_r[7:6] == 2'h0) op = OP_PTR;
      end
      `LTD_OPC_TBL: begin
        if (ir_r[7:3] == `LTD_TBL_HI5) op = OP_TBL;
      end
      // Any 1111 word, other ops of the core: no-operation here
      default: op = OP_NOP;
    endcase
  end

  // ----------------------------------------------------------------------
  // Shared adder for add and subtract-from-literal
  // ----------------------------------------------------------------------
  always @* begin
    alu_a = working_register_r;
    alu_b = lit;
    alu_cin = 1'b0;
    if (op == OP_SUB) begin
      alu_a = lit;
      alu_b = ~working_register_r;
      alu_cin = 1'b1;
    end
    alu_sum = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, alu_cin};
    alu_nib = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, alu_cin};
    res = alu_sum[7:0];
    flags_nxt = flags_r;
    case (op)
      OP_ADD, OP_SUB: begin
        flags_nxt[`LTD_FLAG_C] = alu_sum[8];
        flags_nxt[`LTD_FLAG_DC] = alu_nib[4];
        flags_nxt[`LTD_FLAG_OV] = (alu_a[7] == alu_b[7]) && (res[7] != alu_a[7]);
      end
      OP_AND: res = working_register_r & lit;
      OP_OR: res = working_register_r | lit;
      OP_XOR: res = working_register_r ^ lit;
      default: res = lit;
    endcase
    // Logic ops touch only zero and negative
    if (op == OP_ADD || op == OP_SUB || op == OP_AND || op == OP_OR || op == OP_XOR) begin
      flags_nxt[`LTD_FLAG_Z] = (res == 8'h00);
      flags_nxt[`LTD_FLAG_N] = res[7];
    end
  end

  // ----------------------------------------------------------------------
  // APB read mux and address check
  // ----------------------------------------------------------------------
  always @* begin
    rd_val = 32'h00000000;
    rd_err = 1'b0;
    case (paddr)
      `LTD_OFF_CTRL: rd_val = {30'h00000000, ctrl_r};
      `LTD_OFF_WORKING_REGISTER: rd_val = {24'h000000, working_register_r};
      `LTD_OFF_STATUS: rd_val = {23'h000000, state_r | ~ir_valid_r, 3'h0, flags_r};
      `LTD_OFF_BSR: rd_val = {24'h000000, bsr_r};
      `LTD_OFF_FSR0: rd_val = {20'h00000, fsr_r[0]};
      `LTD_OFF_FSR1: rd_val = {20'h00000, fsr_r[1]};
      `LTD_OFF_FSR2: rd_val = {20'h00000, fsr_r[2]};
      `LTD_OFF_PROD: rd_val = {16'h0000, prod_r};
      `LTD_OFF_TBLPTR: rd_val[TBLPTR_W-1:0] = tblptr_r;
      `LTD_OFF_TBLLAT: rd_val = {24'h000000, tbllat_r};
      `LTD_OFF_PC: rd_val[PC_W-1:0] = prog_addr_r;
      `LTD_OFF_PORT_B_REGISTER: rd_val = {24'h000000, port_b_pins};
      `LTD_OFF_PORT_B_REGISTER_SET: rd_val = {24'h000000, port_b_out_r};
      `LTD_OFF_TIMER_ZERO_COUNT: rd_val = {24'h000000, timer_zero_count_r};
      default: rd_err = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------------
  // Sequencer, execution and register writes
  // ----------------------------------------------------------------------
  // All state held while the clock enable is low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prog_addr_r <= {PC_W{1'b0}};
      ret_pop_r <= 1'b0;
      tbl_addr_r <= {TBLPTR_W{1'b0}};
      tbl_rd_r <= 1'b0;
      tbl_wr_r <= 1'b0;
      tbl_wdata_r <= `LTD_RST_BYTE;
      port_b_out_r <= `LTD_RST_BYTE;
      timer_zero_count_r <= `LTD_RST_BYTE;
      psc_clr_r <= 1'b0;

      // Internal state, core idle until run is set
      state_r <= ST_RUN;
      ir_r <= `LTD_RST_WORD;
      ir_valid_r <= 1'b0;
      ctrl_r <= `LTD_RST_CTRL;
      working_register_r <= `LTD_RST_BYTE;
      flags_r <= `LTD_RST_FLAGS;
      bsr_r <= `LTD_RST_BYTE;
      prod_r <= `LTD_RST_PROD;
      tblptr_r <= {TBLPTR_W{1'b0}};
      tbllat_r <= `LTD_RST_BYTE;
      for (i = 0; i < 3; i = i + 1) begin
        fsr_r[i] <= `LTD_RST_FSR;
      end
    end else if (ce) begin
      // One-cycle strobes fall by default
      ret_pop_r <= 1'b0;
      tbl_rd_r <= 1'b0;
      tbl_wr_r <= 1'b0;
      psc_clr_r <= 1'b0;

      // APB: one wait state, data and error captured with ready
      pready_r <= apb_acc & ~pready_r;
      if (apb_acc && !pready_r) begin
        prdata_r <= pwrite ? 32'h00000000 : rd_val;
        pslverr_r <= rd_err;
      end

      // Fetch and execute only while run is set
      if (running) begin
        case (state_r)
          ST_RUN: begin
            // Fetch the next word while this one executes
            prog_addr_r <= prog_addr_r + PC_ONE;
            ir_r <= prog_rdata;
            ir_valid_r <= 1'b1;
            if (ir_valid_r) begin
              flags_r <= flags_nxt;
              case (op)
                // Decode, read literal, process, write W in one cycle
                OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_MOV: working_register_r <= res;
                OP_MUL: prod_r <= mul_full;
                OP_BSR: bsr_r[3:0] <= lit[3:0];
                OP_RET: begin
                  // Jump, then one idle cycle while the target is fetched
                  working_register_r <= lit;
                  prog_addr_r <= ret_addr;
                  ret_pop_r <= 1'b1;
                  ir_valid_r <= 1'b0;
                end
                OP_PTR: begin
                  // Second word is consumed as operand, never executed
                  if (ir_r[5:4] != 2'h3) begin
                    fsr_r[ir_r[5:4]] <= {ir_r[3:0], prog_rdata[7:0]};
                  end
                  ir_valid_r <= 1'b0;
                end
                OP_TBL: begin
                  // Hold fetch for the access cycle
                  prog_addr_r <= prog_addr_r;
                  ir_r <= ir_r;
                  state_r <= ST_TBL;
                  tblptr_r <= tbl_pre;
                  tbl_addr_r <= tbl_pre;
                  tbl_rd_r <= ~tbl_is_wr;
                  tbl_wr_r <= tbl_is_wr;
                  tbl_wdata_r <= tbllat_r;
                end
                default: ir_valid_r <= 1'b1;
              endcase
            end
          end
          ST_TBL: begin
            // Second cycle: capture data, post-update pointer, resume fetch
            if (!tbl_is_wr) tbllat_r <= tbl_rdata;
            if (tbl_mode == `LTD_TBL_POSTINC) tblptr_r <= tblptr_r + TP_ONE;
            if (tbl_mode == `LTD_TBL_POSTDEC) tblptr_r <= tblptr_r - TP_ONE;
            prog_addr_r <= prog_addr_r + PC_ONE;
            ir_r <= prog_rdata;
            ir_valid_r <= 1'b1;
            state_r <= ST_RUN;
          end
          default: state_r <= ST_RUN;
        endcase
      end

      // Placed last so a bus write beats an instruction update
      // APB writes take effect on the edge that completes the access
      if (apb_wr) begin
        case (paddr)
          `LTD_OFF_CTRL: ctrl_r <= pwdata[1:0];
          `LTD_OFF_WORKING_REGISTER: working_register_r <= pwdata[7:0];
          `LTD_OFF_TBLPTR: tblptr_r <= pwdata[TBLPTR_W-1:0];
          `LTD_OFF_TBLLAT: tbllat_r <= pwdata[7:0];
          `LTD_OFF_PC: begin
            prog_addr_r <= pwdata[PC_W-1:0];
            ir_valid_r <= 1'b0;
            state_r <= ST_RUN;
          end
          `LTD_OFF_PORT_B_REGISTER: port_b_out_r <= pwdata[7:0];
          // Set bits on top of what the pins show
          `LTD_OFF_PORT_B_REGISTER_SET: port_b_out_r <= port_b_pins | pwdata[7:0];
          `LTD_OFF_TIMER_ZERO_COUNT: begin
            timer_zero_count_r <= pwdata[7:0];
            psc_clr_r <= ctrl_r[`LTD_CTRL_PSC_ASSIGNED];
          end
          default: ctrl_r <= ctrl_r;
        endcase
      end
    end
  end

endmodule

// ---- verilog/ltd_map.vh ----
// Constants for the literal and table operation decoder: offsets, fields, opcodes, resets
`ifndef LTD_MAP_VH
`define LTD_MAP_VH

// ----------------------------------------------------------------------
// APB register byte offsets
// ----------------------------------------------------------------------
`define LTD_OFF_CTRL 8'h00
`define LTD_OFF_WORKING_REGISTER 8'h04
`define LTD_OFF_STATUS 8'h08
`define LTD_OFF_BSR 8'h0C
`define LTD_OFF_FSR0 8'h10
`define LTD_OFF_FSR1 8'h14
`define LTD_OFF_FSR2 8'h18
`define LTD_OFF_PROD 8'h1C
`define LTD_OFF_TBLPTR 8'h20
`define LTD_OFF_TBLLAT 8'h24
`define LTD_OFF_PC 8'h28
`define LTD_OFF_PORT_B_REGISTER 8'h2C
`define LTD_OFF_PORT_B_REGISTER_SET 8'h30
`define LTD_OFF_TIMER_ZERO_COUNT 8'h34

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LTD_CTRL_RUN 0
`define LTD_CTRL_PSC_ASSIGNED 1
`define LTD_FLAG_C 0
`define LTD_FLAG_DC 1
`define LTD_FLAG_Z 2
`define LTD_FLAG_OV 3
`define LTD_FLAG_N 4
`define LTD_STATUS_BUSY 8

// ----------------------------------------------------------------------
// Opcode upper bytes and fixed patterns
// ----------------------------------------------------------------------
`define LTD_OPC_ADD 8'h0F
`define LTD_OPC_AND 8'h0B
`define LTD_OPC_OR 8'h09
`define LTD_OPC_XOR 8'h0A
`define LTD_OPC_SUB 8'h08
`define LTD_OPC_MOV 8'h0E
`define LTD_OPC_MUL 8'h0D
`define LTD_OPC_RET 8'h0C
`define LTD_OPC_BSR 8'h01
`define LTD_OPC_PTR 8'hEE
`define LTD_OPC_TBL 8'h00
`define LTD_TBL_HI5 5'h01
`define LTD_TBL_NONE 2'h0
`define LTD_TBL_POSTINC 2'h1
`define LTD_TBL_POSTDEC 2'h2
`define LTD_TBL_PREINC 2'h3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LTD_RST_BYTE 8'h00
`define LTD_RST_FLAGS 5'h00
`define LTD_RST_CTRL 2'h0
`define LTD_RST_PROD 16'h0000
`define LTD_RST_FSR 12'h000
`define LTD_RST_WORD 16'h0000

`endif

// ---- tb/ltd_monitor.sv ----
// Checker of bus, strobe and side-effect timing at the core ports
`timescale 1ns/1ps
`include "ltd_map.vh"
module ltd_monitor #(parameter PC_W = 20, parameter TBLPTR_W = 21) (
  // Clock, reset and enable
  input logic pclk,
  input logic presetn,
  input logic ce,
  // APB
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata_r,
  input logic pready_r,
  input logic pslverr_r,
  // Core side
  input logic [PC_W-1:0] prog_addr_r,
  input logic [PC_W-1:0] ret_addr,
  input logic [15:0] prog_rdata,
  input logic ret_pop_r,
  input logic tbl_rd_r,
  input logic tbl_wr_r,
  input logic psc_clr_r,
  input logic [TBLPTR_W-1:0] tbl_addr_r,
  input logic [7:0] tbl_wdata_r,
  input logic [7:0] tbl_rdata,
  input logic [7:0] port_b_pins,
  input logic [7:0] port_b_out_r,
  input logic [7:0] timer_zero_count_r
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed writes and address decode
  wire done_wr = psel && penable && pready_r && pwrite;
  wire bad_adr = (paddr[1:0] != 2'h0) || (paddr > 8'h34);
  wire [7:0] wd = pwdata[7:0];
  wire strobe = tbl_rd_r || tbl_wr_r;
  a_ready_wait: assert property ($rose(penable) && psel |=> pready_r)
    else $error("answer not after one wait state");
  a_ready_pulse: assert property (pready_r |-> psel && penable ##1 !pready_r)
    else $error("answer outside access or too long");
  a_err_unmapped: assert property (pready_r |-> pslverr_r == bad_adr)
    else $error("error flag wrong for address");
  a_write_zero: assert property (pready_r && pwrite |-> prdata_r == 32'h0)
    else $error("read data not zero on write");
  a_strobe_single: assert property (strobe |=> !strobe)
    else $error("table strobe longer than one cycle");
  a_table_pc_hold: assert property (strobe |-> $stable(prog_addr_r))
    else $error("fetch moved during table cycle");
  a_ret_target: assert property (ret_pop_r |-> ##[0:2] prog_addr_r == ret_addr)
    else $error("return did not load the stack top");
  a_ret_pulse: assert property (ret_pop_r |=> !ret_pop_r)
    else $error("return pop longer than one cycle");
  a_pins_merge: assert property (done_wr && paddr == `LTD_OFF_PORT_B_REGISTER_SET |=>
    port_b_out_r == ($past(port_b_pins) | $past(wd)))
    else $error("port rewrite not taken from pins");
  a_psc_cause: assert property (psc_clr_r |->
    $past(done_wr && paddr == `LTD_OFF_TIMER_ZERO_COUNT))
    else $error("prescaler clear without timer write");
endmodule
bind ltd_core ltd_monitor #(.PC_W(PC_W), .TBLPTR_W(TBLPTR_W)) mon (.pclk, .presetn, .ce,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_r, .pready_r, .pslverr_r, .prog_addr_r,
  .ret_addr, .prog_rdata, .ret_pop_r, .tbl_rd_r, .tbl_wr_r, .psc_clr_r, .tbl_addr_r,
  .tbl_wdata_r, .tbl_rdata, .port_b_pins, .port_b_out_r, .timer_zero_count_r);

// ---- tb/ltd_prog_mem.sv ----
// Program memory, table memory and return stack top facing the core
`timescale 1ns/1ps
module ltd_prog_mem #(parameter PC_W = 20, parameter TBLPTR_W = 21, parameter RET_AT = 64) (
  // Fetch and return stack
  input logic pclk,
  input logic [PC_W-1:0] prog_addr_r,
  output logic [15:0] prog_rdata,
  output logic [PC_W-1:0] ret_addr,
  // Table access
  input logic [TBLPTR_W-1:0] tbl_addr_r,
  input logic tbl_rd_r,
  input logic tbl_wr_r,
  input logic [7:0] tbl_wdata_r,
  output logic [7:0] tbl_rdata
);
  logic [15:0] mem [0:255];
  logic [7:0] tmem [0:255];
  // Code words start as no-operation, table bytes as a pattern
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'h0000;
      tmem[i] = 8'(i * 7 + 3);
    end
  end
  // Word at the fetch address, no wait
  assign prog_rdata = mem[prog_addr_r[7:0]];
  assign ret_addr = PC_W'(RET_AT);
  // Byte only while the read strobe is up, scrambled otherwise
  assign tbl_rdata = tbl_rd_r ? tmem[tbl_addr_r[7:0]] : ~tmem[tbl_addr_r[7:0]];
  // Latch byte lands on the write strobe
  always @(posedge pclk) begin
    if (tbl_wr_r === 1'b1) begin
      tmem[tbl_addr_r[7:0]] <= tbl_wdata_r;
    end
  end
endmodule

// ---- tb/literal_and_table_op_decoder_bench.sv ----
// Self-checking bench for the literal and table operation decoder
`timescale 1ns/1ps
`include "ltd_map.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module literal_and_table_op_decoder_bench;
  logic pclk, presetn, ce, psel, penable, pwrite, pready_r, pslverr_r, e;
  logic [7:0] paddr, tbl_wdata_r, tbl_rdata, port_b_pins, port_b_out_r, timer_zero_count_r;
  logic [31:0] pwdata, prdata_r, q, r;
  logic [19:0] prog_addr_r, ret_addr, epc;
  logic [15:0] prog_rdata, wd;
  logic ret_pop_r, tbl_rd_r, tbl_wr_r, psc_clr_r;
  logic [20:0] tbl_addr_r, p, pa;
  logic [7:0] k, w, ew, tv;
  logic [4:0] ef;
  logic [12:0] res;
  logic [1:0] m, fs;
  logic [7:0] ops [0:7] = '{`LTD_OPC_ADD, `LTD_OPC_AND, `LTD_OPC_OR, `LTD_OPC_XOR,
    `LTD_OPC_SUB, `LTD_OPC_MOV, `LTD_OPC_RET, `LTD_OPC_MUL};
  int error_cnt = 0, num_checks = 0, psc_n = 0, kind;
  ltd_core DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_r,
    .pready_r, .pslverr_r, .prog_addr_r, .prog_rdata, .ret_addr, .ret_pop_r, .tbl_addr_r,
    .tbl_rd_r, .tbl_wr_r, .tbl_wdata_r, .tbl_rdata, .port_b_pins, .port_b_out_r,
    .timer_zero_count_r, .psc_clr_r);
  ltd_prog_mem pm (.pclk, .prog_addr_r, .prog_rdata, .ret_addr, .tbl_addr_r, .tbl_rd_r,
    .tbl_wr_r, .tbl_wdata_r, .tbl_rdata);
  // Clock
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  // Prescaler clear pulses
  always @(posedge pclk) if (psc_clr_r === 1'b1) psc_n++;
  function automatic [31:0] pointer_load_op(input [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  // Flags and working value after one literal operation
  function automatic [12:0] alu(input [7:0] op, input [7:0] k, input [7:0] w, input [4:0] f);
    logic [8:0] s;
    logic [7:0] y;
    logic c, dc, ov;
    c = f[0];
    dc = f[1];
    ov = f[3];
    case (op)
      `LTD_OPC_ADD: begin
        s = w + k;
        y = s[7:0];
        c = s[8];
        dc = (w[3:0] + k[3:0]) > 15;
        ov = (w[7] == k[7]) && (y[7] != w[7]);
      end
      `LTD_OPC_SUB: begin
        y = k - w;
        c = k >= w;
        dc = k[3:0] >= w[3:0];
        ov = (k[7] != w[7]) && (y[7] != k[7]);
      end
      `LTD_OPC_AND: y = k & w;
      `LTD_OPC_OR: y = k | w;
      `LTD_OPC_XOR: y = k ^ w;
      `LTD_OPC_MOV, `LTD_OPC_RET: return {f, k};
      default: return {f, w};
    endcase
    return {y[7], ov, y == 8'h0, dc, c, y};
  endfunction
  // One APB transfer; answer taken at the pready edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready_r !== 1'b1) @(posedge pclk);
    q = prdata_r;
    e = pslverr_r;
    psel <= 0;
    penable <= 0;
  endtask
  // Place code, restart fetch at zero, run, stop
  task run_word(input [15:0] w0, input [15:0] w1);
    pm.mem[0] = w0;
    pm.mem[1] = w1;
    apb(1, `LTD_OFF_PC, 0);
    apb(1, `LTD_OFF_CTRL, 1);
    repeat (12) @(posedge pclk);
    apb(1, `LTD_OFF_CTRL, 0);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #400000;
    error_cnt++;
    end_sim;
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, port_b_pins} = 0;
    ce = 1;
    r = 32'h634E;
    ef = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    for (int a = 0; a < 56; a += 4) begin
      apb(0, a[7:0], 0);
      `CHK(q & ((a == 8) ? 32'h1F : 32'hFFFFFFFF), 32'h0)
    end
    for (int i = 0; i < 80; i++) begin
      r = pointer_load_op(r);
      k = (i == 0) ? 8'h15 : r[7:0];
      w = (i == 0) ? 8'h10 : r[15:8];
      kind = (i < 2) ? i * 4 : r[19:16] % 13;
      m = r[21:20];
      fs = r[23:22] % 3;
      p = (i % 7 == 0) ? 21'h0 : {13'h0, r[31:24]};
      pa = (m == 3) ? p + 1 : p;
      tv = pm.tmem[pa[7:0]];
      apb(1, `LTD_OFF_WORKING_REGISTER, {24'h0, w});
      apb(1, `LTD_OFF_TBLPTR, {11'h0, p});
      apb(1, `LTD_OFF_TBLLAT, {24'h0, k});
      case (kind)
        8: wd = {8'h01, 4'h0, k[3:0]};
        9: wd = {8'hEE, 2'b00, fs, k[3:0]};
        10: wd = {14'h0002, m};
        11: wd = {14'h0003, m};
        12: wd = {8'hF0, k};
        default: wd = {ops[kind], k};
      endcase
      run_word(wd, (kind == 9) ? {8'hF0, r[31:24]} : 16'h0000);
      res = alu((kind < 8) ? ops[kind] : 8'hFF, k, w, ef);
      ew = res[7:0];
      ef = res[12:8];
      apb(0, `LTD_OFF_WORKING_REGISTER, 0);
      `CHK(q[7:0], ew)
      apb(0, `LTD_OFF_STATUS, 0);
      `CHK(q[4:0], ef)
      // Sixteen fetch steps per run; return jumps, a table access holds the fetch once
      epc = (kind == 6) ? ret_addr + 20'h0E : (kind == 10 || kind == 11) ? 20'h0F : 20'h10;
      apb(0, `LTD_OFF_PC, 0);
      `CHK(q[19:0], epc)
      if (kind == 7) begin
        apb(0, `LTD_OFF_PROD, 0);
        `CHK(q[15:0], {8'h0, k} * {8'h0, w})
      end
      if (kind == 8) begin
        apb(0, `LTD_OFF_BSR, 0);
        `CHK(q[7:0], {4'h0, k[3:0]})
      end
      if (kind == 9) begin
        apb(0, `LTD_OFF_FSR0 + {fs, 2'b00}, 0);
        `CHK(q[11:0], {k[3:0], r[31:24]})
      end
      if (kind == 10 || kind == 11) begin
        apb(0, `LTD_OFF_TBLPTR, 0);
        `CHK(q[20:0], (m == 0) ? p : (m == 2) ? p - 21'h1 : p + 21'h1)
        apb(0, `LTD_OFF_TBLLAT, 0);
        `CHK(q[7:0], (kind == 10) ? tv : k)
        if (kind == 11) `CHK(pm.tmem[pa[7:0]], k)
      end
    end
    // Port rewrite from pins, timer write with prescaler, unmapped places
    port_b_pins <= r[7:0];
    apb(1, `LTD_OFF_PORT_B_REGISTER, 32'hFF);
    apb(1, `LTD_OFF_PORT_B_REGISTER_SET, {24'h0, r[15:8]});
    apb(0, `LTD_OFF_PORT_B_REGISTER_SET, 0);
    `CHK(q[7:0], r[7:0] | r[15:8])
    apb(1, `LTD_OFF_CTRL, 2);
    apb(1, `LTD_OFF_TIMER_ZERO_COUNT, {24'h0, k});
    apb(0, `LTD_OFF_TIMER_ZERO_COUNT, 0);
    `CHK(q[7:0], k)
    apb(1, `LTD_OFF_CTRL, 0);
    apb(1, `LTD_OFF_TIMER_ZERO_COUNT, 0);
    `CHK(psc_n, 1)
    apb(0, 8'h3C, 0);
    `CHK({e, q}, 33'h100000000)
    apb(1, 8'h05, 32'h1);
    `CHK(e, 1'b1)
    end_sim;
  end
endmodule
